// file: common/tpl_pkg.sv
package tpl_pkg;
	localparam int          AW          = 8;
	localparam int          DW          = 32;
	localparam int          SW          = 16;
	localparam int          CW          = 10;
	// register byte offsets
	localparam logic [7:0]  OFS_CFG     = 8'h00;
	localparam logic [7:0]  OFS_SPD_LIM = 8'h04;
	localparam logic [7:0]  OFS_P_FILT  = 8'h08;
	localparam logic [7:0]  OFS_T_DLY   = 8'h0C;
	localparam logic [7:0]  OFS_P_THR   = 8'h10;
	localparam logic [7:0]  OFS_T_THR   = 8'h14;
	localparam logic [7:0]  OFS_STAT    = 8'h18;
	// config fields, channel 0 pressure, channel 1 temperature, 4 bits each
	localparam int          CH_STRIDE   = 4;
	localparam int          F_EN        = 0;
	localparam int          F_CAN       = 1;
	localparam int          F_POL       = 2;
	localparam int          F_SNS       = 3;
	localparam int          F_SEAT_EN   = 8;
	localparam int          F_SEAT_CAN  = 9;
	// reset values
	localparam logic [9:0]  CFG_RST     = 10'h000;
	localparam logic [15:0] SPD_LIM_RST = 16'h0064;
	localparam logic [15:0] P_FILT_RST  = 16'h01F4;
	localparam logic [15:0] T_DLY_RST   = 16'h1388;
	localparam logic [15:0] P_THR_RST   = 16'h0000;
	localparam int          TEMP_LIMIT_C = 120;
	localparam logic [15:0] T_THR_RST   = 16'(TEMP_LIMIT_C);

	typedef enum logic [1:0] {
		TPL_DIR_N = 2'h0,
		TPL_DIR_F = 2'h1,
		TPL_DIR_R = 2'h2
	} tpl_dir_e;

	typedef enum logic [1:0] {
		LT_IDLE   = 2'h0,
		LT_HOLD   = 2'h1,
		LT_SEEN_N = 2'h3
	} tpl_latch_e;

	typedef struct packed {
		logic seat_sw;
		logic temp_sw;
		logic press_sw;
	} tpl_host_frame_s;

	typedef struct packed {
		logic [15:0] press_val;
		logic [15:0] temp_val;
	} tpl_frame_one_s;

	typedef struct packed {
		logic dir_block;
		logic force_n;
		logic seat_rot;
		logic seat_en;
		logic temp_high;
		logic press_low;
	} tpl_frame_two_s;
endpackage : tpl_pkg

// file: hdl/tpl_top.sv
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module tpl_top (
	input  wire logic                       mclk,
	input  wire logic                       rst_b,
	input  wire logic [tpl_pkg::AW-1:0]     reg_addr,
	input  wire logic [tpl_pkg::DW-1:0]     reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [tpl_pkg::DW-1:0]     reg_rdata,
	input  wire logic                       pin_press_sw,
	input  wire logic                       pin_temp_sw,
	input  wire logic                       pin_seat_sw,
	input  wire logic [1:0]                 pin_lever,
	input  wire logic [tpl_pkg::SW-1:0]     vehicle_speed,
	input  wire logic [tpl_pkg::SW-1:0]     press_value,
	input  wire logic [tpl_pkg::SW-1:0]     temp_value,
	input  wire logic                       host_frame_valid,
	input  wire tpl_pkg::tpl_host_frame_s   host_to_ctrl_frame_one,
	output tpl_pkg::tpl_frame_one_s         ctrl_to_host_frame_one,
	output tpl_pkg::tpl_frame_two_s         ctrl_to_host_frame_two,
	output tpl_pkg::tpl_dir_e               trans_dir,
	output logic                            range_shift_ok
);

////////////////////////////////////////////////////////////////////////////////
// reset release and pin synchronisers

	logic                     rst_s1_ff;
	logic                     rst_n_ff;
	logic [4:0]               sy1_ff;
	logic [4:0]               sy2_ff;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff  <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff  <= rst_s1_ff;
		end
	end

	// lever bits are synced apart; a transient code 3 is read as neutral
	always_ff @(posedge mclk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			sy1_ff <= 5'h00;
			sy2_ff <= 5'h00;
		end else begin
			sy1_ff <= {pin_lever, pin_seat_sw, pin_temp_sw, pin_press_sw};
			sy2_ff <= sy1_ff;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// registers

	logic [tpl_pkg::CW-1:0]   cfg_ff;
	logic [15:0]              spd_lim_ff;
	logic [15:0]              lim_ff [2];
	logic [15:0]              thr_ff [2];
	logic [tpl_pkg::DW-1:0]   rdata_ff;
	logic [2:0]               host_ff;
	logic [1:0]               fault_ff;
	logic [15:0]              cnt_ff [2];
	tpl_pkg::tpl_latch_e      latch_ff;
	tpl_pkg::tpl_dir_e        dir_ff;
	tpl_pkg::tpl_dir_e        last_ff;
	logic                     seat_rot;

	// limits take their defaults at reset and may be reprogrammed later
	always_ff @(posedge mclk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			cfg_ff     <= tpl_pkg::CFG_RST;
			spd_lim_ff <= tpl_pkg::SPD_LIM_RST;
			lim_ff[0]  <= tpl_pkg::P_FILT_RST;
			lim_ff[1]  <= tpl_pkg::T_DLY_RST;
			thr_ff[0]  <= tpl_pkg::P_THR_RST;
			thr_ff[1]  <= tpl_pkg::T_THR_RST;
		end else if (reg_wr) begin
			if (reg_addr == tpl_pkg::OFS_CFG) begin
				cfg_ff <= reg_wdata[tpl_pkg::CW-1:0];
			end else if (reg_addr == tpl_pkg::OFS_SPD_LIM) begin
				spd_lim_ff <= reg_wdata[15:0];
			end else if (reg_addr == tpl_pkg::OFS_P_FILT) begin
				lim_ff[0] <= reg_wdata[15:0];
			end else if (reg_addr == tpl_pkg::OFS_T_DLY) begin
				lim_ff[1] <= reg_wdata[15:0];
			end else if (reg_addr == tpl_pkg::OFS_P_THR) begin
				thr_ff[0] <= reg_wdata[15:0];
			end else if (reg_addr == tpl_pkg::OFS_T_THR) begin
				thr_ff[1] <= reg_wdata[15:0];
			end
		end
	end

	logic [tpl_pkg::DW-1:0]   nxt_rdata;

	always_comb begin
		nxt_rdata = '0;
		if (reg_addr == tpl_pkg::OFS_CFG) begin
			nxt_rdata = {22'h000000, cfg_ff};
		end else if (reg_addr == tpl_pkg::OFS_SPD_LIM) begin
			nxt_rdata = {16'h0000, spd_lim_ff};
		end else if (reg_addr == tpl_pkg::OFS_P_FILT) begin
			nxt_rdata = {16'h0000, lim_ff[0]};
		end else if (reg_addr == tpl_pkg::OFS_T_DLY) begin
			nxt_rdata = {16'h0000, lim_ff[1]};
		end else if (reg_addr == tpl_pkg::OFS_P_THR) begin
			nxt_rdata = {16'h0000, thr_ff[0]};
		end else if (reg_addr == tpl_pkg::OFS_T_THR) begin
			nxt_rdata = {16'h0000, thr_ff[1]};
		end else if (reg_addr == tpl_pkg::OFS_STAT) begin
			nxt_rdata = {23'h000000, last_ff, latch_ff, dir_ff, seat_rot, fault_ff};
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge mclk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= reg_rd ? nxt_rdata : '0;
		end
	end

	assign reg_rdata = rdata_ff;

	always_ff @(posedge mclk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			host_ff <= 3'h0;
		end else if (host_frame_valid) begin
			host_ff <= host_to_ctrl_frame_one;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// pressure and temperature channels

	logic [15:0]              sval [2];
	logic [1:0]               raw;

	assign sval[0] = press_value;
	assign sval[1] = temp_value;

	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		localparam int B = ch * tpl_pkg::CH_STRIDE;
		logic sw;
		logic act;
		logic cmp;

		assign sw  = cfg_ff[B+tpl_pkg::F_CAN] ? host_ff[ch] : sy2_ff[ch];
		assign act = cfg_ff[B+tpl_pkg::F_POL] ? sw : ~sw;
		// pressure trips below threshold, temperature above it
		assign cmp = (ch == 0) ? (sval[ch] < thr_ff[ch]) : (sval[ch] > thr_ff[ch]);
		// one source per channel, chosen by the sensor bit
		assign raw[ch] = cfg_ff[B+tpl_pkg::F_EN]
			& (cfg_ff[B+tpl_pkg::F_SNS] ? cmp : act);

		// fault after raw holds lim+1 cycles; >= so a lowered limit cannot wrap the count
		always_ff @(posedge mclk or negedge rst_n_ff) begin
			if (!rst_n_ff) begin
				cnt_ff[ch]   <= 16'h0000;
				fault_ff[ch] <= 1'b0;
			end else if (!raw[ch]) begin
				cnt_ff[ch]   <= 16'h0000;
				fault_ff[ch] <= 1'b0;
			end else if (cnt_ff[ch] >= lim_ff[ch]) begin
				fault_ff[ch] <= 1'b1;
			end else begin
				cnt_ff[ch] <= cnt_ff[ch] + 16'h0001;
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// seat mapping, neutral latch and direction

	tpl_pkg::tpl_dir_e        lever;
	tpl_pkg::tpl_dir_e        req;
	tpl_pkg::tpl_dir_e        nxt_dir;
	logic                     force_n;
	logic                     dir_block;

	assign lever = (sy2_ff[4:3] == 2'h3) ? tpl_pkg::TPL_DIR_N : tpl_pkg::tpl_dir_e'(sy2_ff[4:3]);
	// one bit: normal or rotated, nothing else
	assign seat_rot = cfg_ff[tpl_pkg::F_SEAT_EN]
		& (cfg_ff[tpl_pkg::F_SEAT_CAN] ? host_ff[2] : sy2_ff[2]);

	always_comb begin
		req = tpl_pkg::TPL_DIR_N;
		case (lever)
			tpl_pkg::TPL_DIR_F: begin
				req = seat_rot ? tpl_pkg::TPL_DIR_R : tpl_pkg::TPL_DIR_F;
			end
			tpl_pkg::TPL_DIR_R: begin
				req = seat_rot ? tpl_pkg::TPL_DIR_F : tpl_pkg::TPL_DIR_R;
			end
			default: begin
				req = tpl_pkg::TPL_DIR_N;
			end
		endcase
	end

	// a new fault wins over the lever clearing the latch
	always_ff @(posedge mclk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			latch_ff <= tpl_pkg::LT_IDLE;
		end else if (|fault_ff) begin
			latch_ff <= tpl_pkg::LT_HOLD;
		end else begin
			case (latch_ff)
				tpl_pkg::LT_HOLD: begin
					if (lever == tpl_pkg::TPL_DIR_N) begin
						latch_ff <= tpl_pkg::LT_SEEN_N;
					end
				end
				tpl_pkg::LT_SEEN_N: begin
					if (lever != tpl_pkg::TPL_DIR_N) begin
						latch_ff <= tpl_pkg::LT_IDLE;
					end
				end
				default: begin
					latch_ff <= tpl_pkg::LT_IDLE;
				end
			endcase
		end
	end

	assign force_n = (|fault_ff) | (latch_ff != tpl_pkg::LT_IDLE);
	// no enable term: the speed check cannot be turned off
	assign dir_block = (req != tpl_pkg::TPL_DIR_N) && (last_ff != tpl_pkg::TPL_DIR_N)
		&& (req != last_ff) && (vehicle_speed > spd_lim_ff);

	// a refused change waits in neutral; last_ff keeps it refused until slow
	assign nxt_dir = (force_n || dir_block) ? tpl_pkg::TPL_DIR_N : req;

	always_ff @(posedge mclk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			dir_ff  <= tpl_pkg::TPL_DIR_N;
			last_ff <= tpl_pkg::TPL_DIR_N;
		end else begin
			dir_ff <= nxt_dir;
			if (nxt_dir != tpl_pkg::TPL_DIR_N) begin
				last_ff <= nxt_dir;
			end
		end
	end

	assign trans_dir      = dir_ff;
	assign range_shift_ok = ~fault_ff[0];

////////////////////////////////////////////////////////////////////////////////
// status frames

	always_ff @(posedge mclk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			ctrl_to_host_frame_one <= '0;
			ctrl_to_host_frame_two <= '0;
		end else begin
			ctrl_to_host_frame_one.press_val <= press_value;
			ctrl_to_host_frame_one.temp_val  <= temp_value;
			ctrl_to_host_frame_two.press_low <= fault_ff[0];
			ctrl_to_host_frame_two.temp_high <= fault_ff[1];
			ctrl_to_host_frame_two.seat_en   <= cfg_ff[tpl_pkg::F_SEAT_EN];
			ctrl_to_host_frame_two.seat_rot  <= seat_rot;
			ctrl_to_host_frame_two.force_n   <= force_n;
			ctrl_to_host_frame_two.dir_block <= dir_block;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// assertions

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n_ff);

	sequence s_opposite_fast;
		dir_block && !force_n;
	endsequence

	sequence s_fault_seen;
		fault_ff != 2'h0;
	endsequence

	AST_DIR_BLOCK: assert property (s_opposite_fast |=> trans_dir == tpl_pkg::TPL_DIR_N)
		else $error("direction change taken above speed limit");

	AST_NO_DISABLE: assert property (dir_block |=> last_ff == $past(last_ff))
		else $error("refused direction was engaged");

	AST_PRESS_NEUTRAL: assert property (fault_ff[0] |=> trans_dir == tpl_pkg::TPL_DIR_N)
		else $error("low pressure did not force neutral");

	AST_LATCH_HOLD: assert property (s_fault_seen ##1 (fault_ff == 2'h0 && lever != tpl_pkg::TPL_DIR_N)
		|=> trans_dir == tpl_pkg::TPL_DIR_N)
		else $error("direction re-engaged without lever through neutral");

	AST_TEMP_LATCH: assert property ($fell(fault_ff[1]) |-> latch_ff == tpl_pkg::LT_HOLD)
		else $error("over temperature latch not held");

	AST_RANGE_BLOCK: assert property (fault_ff[0] |-> !range_shift_ok)
		else $error("range shift allowed at low pressure");

	AST_P_FILTER: assert property (!fault_ff[0] && cnt_ff[0] < lim_ff[0] |=> !fault_ff[0])
		else $error("pressure fault before filter time");

	AST_T_DELAY: assert property (!fault_ff[1] && cnt_ff[1] < lim_ff[1] |=> !fault_ff[1])
		else $error("temperature fault before delay");

	AST_STAT_TWO: assert property (##1 ctrl_to_host_frame_two.press_low == $past(fault_ff[0])
		&& ctrl_to_host_frame_two.seat_rot == $past(seat_rot))
		else $error("frame two status mismatch");

	AST_SEAT_MAP: assert property (seat_rot && lever == tpl_pkg::TPL_DIR_F && !force_n && !dir_block
		|=> trans_dir == tpl_pkg::TPL_DIR_R)
		else $error("rotated seat forward did not engage reverse");

endmodule : tpl_top

// file: verif/tpl_partner.sv
`timescale 1ns/1ps
module tpl_partner (
	input  wire logic                     mclk,
	input  wire logic                     send,
	input  wire tpl_pkg::tpl_host_frame_s want,
	output logic                          host_frame_valid,
	output tpl_pkg::tpl_host_frame_s      host_to_ctrl_frame_one
);
	////////////////////////////////////////////////////////////////////////////////
	// the bus toggles between frames, so a design that samples without valid sees junk
	initial begin
		host_frame_valid       = 1'b0;
		host_to_ctrl_frame_one = 3'h0;
	end
	always @(posedge mclk) begin
		host_frame_valid       <= send;
		host_to_ctrl_frame_one <= send ? want : ~host_to_ctrl_frame_one;
	end
endmodule : tpl_partner

// file: verif/transmission_protection_logic_tb_top.sv
`timescale 1ns/1ps
module transmission_protection_logic_tb_top;
	typedef struct packed {
		logic [1:0]        lever;
		logic              seat;
		tpl_pkg::tpl_dir_e dir;
	} tpl_row_s;
	logic                     mclk = 1'b0;
	logic                     rst_b = 1'b0;
	logic [7:0]               reg_addr = 8'h00;
	logic [31:0]              reg_wdata = 32'h0;
	logic                     reg_wr = 1'b0;
	logic                     reg_rd = 1'b0;
	logic [31:0]              reg_rdata;
	logic                     pin_press_sw = 1'b0;
	logic                     pin_temp_sw = 1'b0;
	logic                     pin_seat_sw = 1'b0;
	logic [1:0]               pin_lever = 2'h0;
	logic [15:0]              vehicle_speed = 16'h0;
	logic [15:0]              press_value = 16'h0;
	logic [15:0]              temp_value = 16'h0;
	logic                     fr_send = 1'b0;
	tpl_pkg::tpl_host_frame_s fr_want = 3'h0;
	logic                     fr_valid;
	tpl_pkg::tpl_host_frame_s fr_host;
	tpl_pkg::tpl_frame_one_s  fr_one;
	tpl_pkg::tpl_frame_two_s  fr_two;
	tpl_pkg::tpl_dir_e        trans_dir;
	logic                     range_shift_ok;
	int                       fails = 0;
	int                       check_count = 0;
	logic [7:0]               ra [6] = '{tpl_pkg::OFS_CFG, tpl_pkg::OFS_SPD_LIM,
		tpl_pkg::OFS_P_FILT, tpl_pkg::OFS_T_DLY, tpl_pkg::OFS_P_THR, tpl_pkg::OFS_T_THR};
	logic [31:0]              rv [6] = '{32'h0, 32'h64, 32'h1F4, 32'h1388, 32'h0, 32'h78};
	tpl_row_s                 rows [6] = '{'{2'h1, 1'b0, tpl_pkg::TPL_DIR_F},
		'{2'h2, 1'b0, tpl_pkg::TPL_DIR_R}, '{2'h0, 1'b0, tpl_pkg::TPL_DIR_N},
		'{2'h1, 1'b1, tpl_pkg::TPL_DIR_R}, '{2'h2, 1'b1, tpl_pkg::TPL_DIR_F},
		'{2'h3, 1'b1, tpl_pkg::TPL_DIR_N}};

	always #2 mclk = ~mclk;

	tpl_top DUT (
		.mclk                   (mclk),
		.rst_b                  (rst_b),
		.reg_addr               (reg_addr),
		.reg_wdata              (reg_wdata),
		.reg_wr                 (reg_wr),
		.reg_rd                 (reg_rd),
		.reg_rdata              (reg_rdata),
		.pin_press_sw           (pin_press_sw),
		.pin_temp_sw            (pin_temp_sw),
		.pin_seat_sw            (pin_seat_sw),
		.pin_lever              (pin_lever),
		.vehicle_speed          (vehicle_speed),
		.press_value            (press_value),
		.temp_value             (temp_value),
		.host_frame_valid       (fr_valid),
		.host_to_ctrl_frame_one (fr_host),
		.ctrl_to_host_frame_one (fr_one),
		.ctrl_to_host_frame_two (fr_two),
		.trans_dir              (trans_dir),
		.range_shift_ok         (range_shift_ok)
	);

	tpl_partner u_partner (
		.mclk                   (mclk),
		.send                   (fr_send),
		.want                   (fr_want),
		.host_frame_valid       (fr_valid),
		.host_to_ctrl_frame_one (fr_host)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd

	// bounded wait, then compare whatever direction stands
	task automatic wait_dir(input tpl_pkg::tpl_dir_e exp);
		// never judge in the edge's own time step, the old value could pass
		cyc(1);
		repeat (60) if (trans_dir !== exp) cyc(1);
		chk(32'(trans_dir), 32'(exp));
	endtask : wait_dir

	task automatic lever(input logic [1:0] l);
		@(posedge mclk);
		pin_lever <= l;
	endtask : lever

	task automatic send(input tpl_pkg::tpl_host_frame_s f);
		@(posedge mclk);
		fr_send <= 1'b1;
		fr_want <= f;
		@(posedge mclk);
		fr_send <= 1'b0;
	endtask : send

	task automatic relever(input tpl_pkg::tpl_dir_e exp);
		lever(2'h0);
		cyc(8);
		lever(2'h2);
		wait_dir(exp);
	endtask : relever

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		cyc(4);
		for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
		wr(8'h1C, 32'hFFFF);
		rd(8'h1C, 32'h0);
		wr(tpl_pkg::OFS_STAT, 32'h1FF);
		rd(tpl_pkg::OFS_STAT, 32'h0);
		$display("test registers done");
		wr(tpl_pkg::OFS_CFG, 32'h100);
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk);
			pin_lever   <= rows[i].lever;
			pin_seat_sw <= rows[i].seat;
			wait_dir(rows[i].dir);
			cyc(2);
			chk(32'(fr_two.seat_rot), 32'(rows[i].seat));
		end
		$display("test seat table done");
		// limit kept within the application maximum by the configuring side
		wr(tpl_pkg::OFS_SPD_LIM, 32'h50);
		wr(tpl_pkg::OFS_CFG, 32'h0);
		lever(2'h1);
		wait_dir(tpl_pkg::TPL_DIR_F);
		@(posedge mclk);
		vehicle_speed <= 16'h0051;
		lever(2'h2);
		wait_dir(tpl_pkg::TPL_DIR_N);
		chk(32'(fr_two.dir_block), 32'h1);
		@(posedge mclk);
		vehicle_speed <= 16'h0050;
		wait_dir(tpl_pkg::TPL_DIR_R);
		$display("test direction block done");
		wr(tpl_pkg::OFS_P_FILT, 32'h3);
		wr(tpl_pkg::OFS_CFG, 32'h5);
		// a dip of three samples is one short of the filter
		@(posedge mclk);
		pin_press_sw <= 1'b1;
		cyc(2);
		@(posedge mclk);
		pin_press_sw <= 1'b0;
		cyc(12);
		chk(32'(trans_dir), 32'(tpl_pkg::TPL_DIR_R));
		@(posedge mclk);
		pin_press_sw <= 1'b1;
		wait_dir(tpl_pkg::TPL_DIR_N);
		cyc(2);
		chk(32'(range_shift_ok), 32'h0);
		chk(32'(fr_two.press_low), 32'h1);
		chk(32'(fr_two.force_n), 32'h1);
		@(posedge mclk);
		pin_press_sw <= 1'b0;
		cyc(12);
		chk(32'(trans_dir), 32'(tpl_pkg::TPL_DIR_N));
		chk(32'(range_shift_ok), 32'h1);
		relever(tpl_pkg::TPL_DIR_R);
		wr(tpl_pkg::OFS_CFG, 32'h1);
		wait_dir(tpl_pkg::TPL_DIR_N);
		@(posedge mclk);
		pin_press_sw <= 1'b1;
		relever(tpl_pkg::TPL_DIR_R);
		$display("test pressure done");
		wr(tpl_pkg::OFS_T_DLY, 32'h5);
		wr(tpl_pkg::OFS_CFG, 32'h70);
		send(3'b010);
		cyc(3);
		chk(32'(trans_dir), 32'(tpl_pkg::TPL_DIR_R));
		wait_dir(tpl_pkg::TPL_DIR_N);
		cyc(2);
		chk(32'(fr_two.temp_high), 32'h1);
		send(3'b000);
		cyc(12);
		chk(32'(trans_dir), 32'(tpl_pkg::TPL_DIR_N));
		relever(tpl_pkg::TPL_DIR_R);
		// wired switch, active low: the idle pin reads as over temperature
		wr(tpl_pkg::OFS_CFG, 32'h10);
		wait_dir(tpl_pkg::TPL_DIR_N);
		@(posedge mclk);
		pin_temp_sw <= 1'b1;
		relever(tpl_pkg::TPL_DIR_R);
		$display("test temperature done");
		@(posedge mclk);
		press_value <= 16'h1234;
		temp_value  <= 16'h00AB;
		cyc(3);
		chk(fr_one, 32'h123400AB);
		// switch pin reads as low pressure here, only the sensor may count
		@(posedge mclk);
		pin_press_sw <= 1'b1;
		wr(tpl_pkg::OFS_P_THR, 32'h1000);
		wr(tpl_pkg::OFS_CFG, 32'hD);
		cyc(12);
		chk(32'(trans_dir), 32'(tpl_pkg::TPL_DIR_R));
		@(posedge mclk);
		press_value <= 16'h0FFF;
		wait_dir(tpl_pkg::TPL_DIR_N);
		@(posedge mclk);
		press_value <= 16'h1234;
		relever(tpl_pkg::TPL_DIR_R);
		$display("test sensors done");
		wr(tpl_pkg::OFS_CFG, 32'h300);
		send(3'b100);
		wait_dir(tpl_pkg::TPL_DIR_F);
		chk(32'(fr_two.seat_en), 32'h1);
		$display("test seat frame done");
		// mid-run reset: outputs clear at once, limits reload their defaults
		@(posedge mclk);
		rst_b <= 1'b0;
		cyc(1);
		chk(32'(trans_dir), 32'(tpl_pkg::TPL_DIR_N));
		chk(32'(range_shift_ok), 32'h1);
		chk(32'(fr_two), 32'h0);
		chk(reg_rdata, 32'h0);
		@(posedge mclk);
		rst_b <= 1'b1;
		cyc(2);
		rd(tpl_pkg::OFS_SPD_LIM, 32'(tpl_pkg::SPD_LIM_RST));
		rd(tpl_pkg::OFS_CFG, 32'(tpl_pkg::CFG_RST));
		wait_dir(tpl_pkg::TPL_DIR_R);
		$display("test reset done");
		results();
	end

	initial begin
		#(4 * 20000);
		fails++;
		results();
	end
endmodule : transmission_protection_logic_tb_top
